// ---- adc_cfg_pkg.sv ----
// shared addresses, field positions and reset values of the converter configuration bank
package adc_cfg_pkg;
  localparam logic [7:0] ADDR_PORT_CFG    = 8'h00;
  localparam logic [7:0] ADDR_PART_ID     = 8'h01;
  localparam logic [7:0] ADDR_SPEED_GRADE = 8'h02;
  localparam logic [7:0] ADDR_CHAN_SEL    = 8'h05;
  localparam logic [7:0] ADDR_FUNC_FIRST  = 8'h08;
  localparam logic [7:0] ADDR_CLOCK_OPT   = 8'h09;
  localparam logic [7:0] ADDR_FUNC_LAST   = 8'h53;
  localparam logic [7:0] ADDR_COMMIT      = 8'hff;

  localparam logic [7:0] RST_PORT_CFG  = 8'h18;
  localparam logic [3:0] RST_CHAN_SEL  = 4'hf;
  localparam logic [7:0] RST_CLOCK_OPT = 8'h01;
  localparam logic [7:0] RST_FUNC      = 8'h00;
  localparam logic       RST_COMMIT    = 1'b0;

  localparam int PCFG_SOFT_RST_BIT = 5;
  localparam int PCFG_LSB_BIT      = 6;
  localparam int PCFG_SDO_BIT      = 7;
  localparam int CLK_DCS_BIT       = 0;
  localparam int COMMIT_BIT        = 0;
  localparam int GRADE_LSB         = 4;

  localparam int NUM_CHAN   = 4;
  localparam int FUNC_DEPTH = 76;
  localparam int FUNC_IW    = 7;
  localparam int CLOCK_IDX  = 1;
endpackage

// ---- conv_reg_bank.sv ----
// staging and active copies of one channel's converter function registers
module conv_reg_bank
  import adc_cfg_pkg::*;
#(
  parameter int DEPTH = FUNC_DEPTH
) (
  // clock and reset
  input  wire logic               core_clk_i,
  input  wire logic               rst_i,
  input  wire logic               soft_rst_i,
  // staging write and transfer
  input  wire logic               wr_i,
  input  wire logic [FUNC_IW-1:0] wr_idx_i,
  input  wire logic [7:0]         wdata_i,
  input  wire logic               commit_i,
  // read ports
  input  wire logic [FUNC_IW-1:0] stage_idx_i,
  output logic      [7:0]         stage_o,
  input  wire logic [FUNC_IW-1:0] act_idx_i,
  output logic      [7:0]         act_o,
  output logic      [7:0]         act_clock_o
);
  logic [7:0] stage_reg  [DEPTH];
  logic [7:0] stage_next [DEPTH];
  logic [7:0] act_reg    [DEPTH];
  logic [7:0] act_next   [DEPTH];

  function automatic logic [7:0] default_of(input int i);
    return (i == CLOCK_IDX) ? RST_CLOCK_OPT : RST_FUNC;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      stage_next[i] = stage_reg[i];
      act_next[i]   = act_reg[i];
      if (soft_rst_i) begin
        stage_next[i] = default_of(i);
        act_next[i]   = default_of(i);
      end else begin
        // copy uses the old staged value, so a write in the transfer cycle waits
        if (commit_i) begin
          act_next[i] = stage_reg[i];
        end
        if (wr_i && (int'(wr_idx_i) == i)) begin
          stage_next[i] = wdata_i;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    for (int i = 0; i < DEPTH; i++) begin
      if (rst_i) begin
        stage_reg[i] <= default_of(i);
        act_reg[i]   <= default_of(i);
      end else begin
        stage_reg[i] <= stage_next[i];
        act_reg[i]   <= act_next[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign stage_o     = (int'(stage_idx_i) < DEPTH) ? stage_reg[stage_idx_i] : 8'h00;
  assign act_o       = (int'(act_idx_i) < DEPTH) ? act_reg[act_idx_i] : 8'h00;
  assign act_clock_o = act_reg[CLOCK_IDX];
endmodule

// ---- adc_cfg_regs.sv ----
// configuration register bank of a quad converter: staging copy, transfer, active copy
module adc_cfg_regs
  import adc_cfg_pkg::*;
#(
  parameter logic [7:0] PART_ID     = 8'h5a, // arbitrary value
  parameter logic [2:0] SPEED_GRADE = 3'h2   // arbitrary value
) (
  // clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  // register access from the serial port engine
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  output logic            reg_rvalid_o,
  // active settings toward the converter core
  input  wire logic [1:0] act_chan_i,
  input  wire logic [7:0] act_addr_i,
  output logic      [7:0] act_data_o,
  output logic            dcs_enable_o,
  output logic      [3:0] chan_select_o,
  output logic            lsb_first_o,
  output logic            sdo_active_o,
  output logic            commit_pending_o
);
  logic [7:0] port_cfg_reg, port_cfg_next;
  logic [3:0] chan_sel_reg, chan_sel_next;
  logic       commit_reg, commit_next;
  logic       soft_rst_reg, soft_rst_next;
  logic [7:0] rdata_reg, rdata_next;
  logic       rvalid_reg, rvalid_next;
  logic [7:0] act_data_reg, act_data_next;
  logic       dcs_reg, dcs_next;

  logic [7:0]         bank_stage [NUM_CHAN];
  logic [7:0]         bank_act   [NUM_CHAN];
  logic [7:0]         act_clock;
  logic [7:0]         bank_clock [NUM_CHAN];
  logic [NUM_CHAN-1:0] bank_wr;
  logic [FUNC_IW-1:0] wr_idx, act_idx;

  function automatic logic in_func(input logic [7:0] a);
    return (a >= ADDR_FUNC_FIRST) && (a <= ADDR_FUNC_LAST);
  endfunction

  function automatic logic [FUNC_IW-1:0] func_idx(input logic [7:0] a);
    logic [7:0] d;
    d = a - ADDR_FUNC_FIRST;
    return d[FUNC_IW-1:0];
  endfunction

  function automatic logic [1:0] first_sel(input logic [3:0] s);
    logic [1:0] r;
    r = 2'h0;
    for (int i = NUM_CHAN - 1; i >= 0; i--) begin
      if (s[i]) begin
        r = 2'(i);
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // channel banks; the clock register is global and reaches every bank
  assign wr_idx  = func_idx(reg_addr_i);
  assign act_idx = func_idx(act_addr_i);

  for (genvar c = 0; c < NUM_CHAN; c++) begin : g_bank
    // select bit 3 is channel A, bit 0 is channel D
    assign bank_wr[c] = reg_wr_i && in_func(reg_addr_i)
                        && (chan_sel_reg[NUM_CHAN-1-c] || reg_addr_i == ADDR_CLOCK_OPT);
    conv_reg_bank #(.DEPTH(FUNC_DEPTH)) u_bank (
      .core_clk_i  (core_clk_i),
      .rst_i       (rst_i),
      .soft_rst_i  (soft_rst_reg),
      .wr_i        (bank_wr[c]),
      .wr_idx_i    (wr_idx),
      .wdata_i     (reg_wdata_i),
      .commit_i    (commit_reg),
      .stage_idx_i (wr_idx),
      .stage_o     (bank_stage[c]),
      .act_idx_i   (act_idx),
      .act_o       (bank_act[c]),
      .act_clock_o (bank_clock[c])
    );
  end

  // the clock register is written into every bank alike, so any copy will do
  assign act_clock = bank_clock[0];

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    port_cfg_next = port_cfg_reg;
    chan_sel_next = chan_sel_reg;
    soft_rst_next = 1'b0;
    // hardware clears the transfer bit after one cycle; a new write wins
    commit_next   = 1'b0;
    if (soft_rst_reg) begin
      port_cfg_next = RST_PORT_CFG;
      chan_sel_next = RST_CHAN_SEL;
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        ADDR_PORT_CFG: begin
          port_cfg_next = reg_wdata_i;
          port_cfg_next[PCFG_SOFT_RST_BIT] = 1'b0;
          soft_rst_next = reg_wdata_i[PCFG_SOFT_RST_BIT];
        end
        ADDR_CHAN_SEL: begin
          chan_sel_next = reg_wdata_i[3:0];
        end
        ADDR_COMMIT: begin
          commit_next = reg_wdata_i[COMMIT_BIT];
        end
        default: begin
          // read-only and undefined locations ignore writes
          port_cfg_next = port_cfg_reg;
        end
      endcase
    end
  end

  always_comb begin
    rvalid_next = reg_rd_i;
    rdata_next  = 8'h00;
    if (reg_rd_i) begin
      if (in_func(reg_addr_i)) begin
        rdata_next = bank_stage[NUM_CHAN-1-int'(first_sel(chan_sel_reg))];
      end else begin
        unique case (reg_addr_i)
          ADDR_PORT_CFG:    rdata_next = {port_cfg_reg[7:6], soft_rst_reg, port_cfg_reg[4:0]};
          ADDR_PART_ID:     rdata_next = PART_ID;
          ADDR_SPEED_GRADE: rdata_next = {1'b0, SPEED_GRADE, 4'h0};
          ADDR_CHAN_SEL:    rdata_next = {4'h0, chan_sel_reg};
          ADDR_COMMIT:      rdata_next = {7'h00, commit_reg};
          default:          rdata_next = 8'h00;
        endcase
      end
    end
    act_data_next = in_func(act_addr_i) ? bank_act[NUM_CHAN-1-int'(act_chan_i)] : 8'h00;
    dcs_next      = act_clock[CLK_DCS_BIT];
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      port_cfg_reg <= RST_PORT_CFG;
      chan_sel_reg <= RST_CHAN_SEL;
      commit_reg   <= RST_COMMIT;
      soft_rst_reg <= 1'b0;
      rdata_reg    <= 8'h00;
      rvalid_reg   <= 1'b0;
      act_data_reg <= RST_FUNC;
      dcs_reg      <= RST_CLOCK_OPT[CLK_DCS_BIT];
    end else begin
      port_cfg_reg <= port_cfg_next;
      chan_sel_reg <= chan_sel_next;
      commit_reg   <= commit_next;
      soft_rst_reg <= soft_rst_next;
      rdata_reg    <= rdata_next;
      rvalid_reg   <= rvalid_next;
      act_data_reg <= act_data_next;
      dcs_reg      <= dcs_next;
    end
  end

  assign reg_rdata_o      = rdata_reg;
  assign reg_rvalid_o     = rvalid_reg;
  assign act_data_o       = act_data_reg;
  assign dcs_enable_o     = dcs_reg;
  assign chan_select_o    = chan_sel_reg;
  assign lsb_first_o      = port_cfg_reg[PCFG_LSB_BIT];
  assign sdo_active_o     = port_cfg_reg[PCFG_SDO_BIT];
  assign commit_pending_o = commit_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_dcs_off_staged;
    reg_wr_i && reg_addr_i == ADDR_CLOCK_OPT && !reg_wdata_i[CLK_DCS_BIT] && !soft_rst_reg;
  endsequence

  sequence s_commit_write;
    reg_wr_i && reg_addr_i == ADDR_COMMIT && reg_wdata_i[COMMIT_BIT];
  endsequence

  a_commit_sets: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (s_commit_write and !soft_rst_reg) |=> commit_pending_o)
    else $error("transfer bit not set by write");

  a_commit_clears: assert property (@(posedge core_clk_i) disable iff (rst_i)
    commit_pending_o && !reg_wr_i |=> !commit_pending_o)
    else $error("transfer bit did not self clear");

  a_dcs_off_flow: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (s_dcs_off_staged ##1 (s_commit_write and !soft_rst_reg)) ##1 !soft_rst_reg
    |-> ##2 !dcs_enable_o)
    else $error("stabilizer not turned off after transfer");

  a_dcs_stable: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !$past(commit_reg, 2) && !$past(soft_rst_reg, 2) && !$past(rst_i, 2)
    |-> $stable(dcs_enable_o))
    else $error("stabilizer changed without transfer");

  a_reset_defaults: assert property (@(posedge core_clk_i)
    $past(rst_i) && !rst_i |-> chan_select_o == RST_CHAN_SEL && dcs_enable_o
                               && !commit_pending_o)
    else $error("defaults not loaded at reset");

  a_read_answer: assert property (@(posedge core_clk_i) disable iff (rst_i)
    reg_rd_i && reg_addr_i == ADDR_PART_ID |=> reg_rvalid_o && reg_rdata_o == PART_ID)
    else $error("part identifier read wrong");

  a_undef_reads_zero: assert property (@(posedge core_clk_i) disable iff (rst_i)
    reg_rd_i && !in_func(reg_addr_i) && reg_addr_i > ADDR_CHAN_SEL
    && reg_addr_i != ADDR_COMMIT |=> reg_rdata_o == 8'h00)
    else $error("undefined address did not read zero");

  a_select_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
    reg_wr_i && reg_addr_i == ADDR_CHAN_SEL && !soft_rst_reg
    |=> chan_select_o == $past(reg_wdata_i[3:0]))
    else $error("channel select not updated");
endmodule

// ---- cfg_host.sv ----
// behavioural serial-port host issuing register strobes to the bank
module cfg_host
  import adc_cfg_pkg::*;
(
  // clock
  input  wire logic       core_clk_i,
  // register strobes toward the bank
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic      [7:0] reg_addr_o,
  output logic      [7:0] reg_wdata_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
  end

  // released lines flip so a stale value is never mistaken for a live one
  // callers keep writes to defined locations or their default values
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    reg_wr_o = 1'b1;
    reg_addr_o = a;
    reg_wdata_o = d;
    @(negedge core_clk_i);
    reg_wr_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask

  task automatic rd(input logic [7:0] a);
    @(negedge core_clk_i);
    reg_rd_o = 1'b1;
    reg_addr_o = a;
    @(negedge core_clk_i);
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
  endtask

  task automatic commit();
    wr(ADDR_COMMIT, 8'h01);
  endtask

  // transfer right behind the staging write; the strobe stays up in between
  task automatic wr_commit(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    reg_wr_o = 1'b1;
    reg_addr_o = a;
    reg_wdata_o = d;
    @(negedge core_clk_i);
    reg_addr_o = ADDR_COMMIT;
    reg_wdata_o = 8'h01;
    @(negedge core_clk_i);
    reg_wr_o = 1'b0;
    reg_addr_o = ~ADDR_COMMIT;
    reg_wdata_o = 8'hfe;
  endtask
endmodule

// ---- adc_cfg_regs_tb_top.sv ----
// self-checking bench for the converter configuration bank
module adc_cfg_regs_tb_top
  import adc_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [7:0] ID    = 8'h3c; // arbitrary value
  localparam logic [2:0] GRADE = 3'h5;  // arbitrary value

  logic       core_clk_i;
  logic       rst_i;
  logic       wr;
  logic       rd;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       rvalid;
  logic [1:0] act_chan;
  logic [7:0] act_addr;
  logic [7:0] act_data;
  logic       dcs;
  logic [3:0] csel;
  logic       lsb_first;
  logic       sdo_active;
  logic       pend;
  int         bad_count;
  int         n_checks;
  logic [7:0] exp_q[$];
  logic [7:0] d[4];

  cfg_host u_cfg_host (.core_clk_i(core_clk_i), .reg_wr_o(wr), .reg_rd_o(rd),
    .reg_addr_o(addr), .reg_wdata_o(wdata));

  adc_cfg_regs #(.PART_ID(ID), .SPEED_GRADE(GRADE)) u_adc_cfg_regs (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid), .act_chan_i(act_chan), .act_addr_i(act_addr),
    .act_data_o(act_data), .dcs_enable_o(dcs), .chan_select_o(csel),
    .lsb_first_o(lsb_first), .sdo_active_o(sdo_active), .commit_pending_o(pend));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic results();
    if (bad_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_cfg_host.rd(a);
  endtask

  task automatic act_chk(input logic [1:0] c, input logic [7:0] a, input logic [7:0] e);
    @(negedge core_clk_i);
    act_chan = c;
    act_addr = a;
    @(negedge core_clk_i);
    chk("active data", act_data, e);
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask

  // read results are judged where they appear, against the oldest note
  always @(negedge core_clk_i) begin
    if (rvalid === 1'b1) begin
      if (exp_q.size() == 0) chk("spurious read", 8'h01, 8'h00);
      else chk("read data", rdata, exp_q.pop_front());
    end
  end

  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  initial begin
    #100000;
    chk("timeout", 8'h01, 8'h00);
    results();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    bad_count = 0;
    n_checks = 0;
    rst_i = 1'b1;
    act_chan = 2'h0;
    act_addr = 8'h09;
    void'($urandom(44));
    idle(20);
    rst_i = 1'b0;
    chk("dcs", {7'h00, dcs}, 8'h01);
    chk("select", {4'h0, csel}, 8'h0f);
    chk("port bits", {6'h00, sdo_active, lsb_first}, 8'h00);
    rd_chk(8'h00, 8'h18);
    rd_chk(8'h01, ID);
    rd_chk(8'h02, {1'b0, GRADE, 4'h0});
    rd_chk(8'h05, 8'h0f);
    rd_chk(8'h09, 8'h01);
    rd_chk(8'hff, 8'h00);
    rd_chk(8'h03, 8'h00);
    rd_chk(8'h54, 8'h00);
    u_cfg_host.wr(8'h01, 8'($urandom));
    rd_chk(8'h01, ID);
    // reserved bits written as zero
    u_cfg_host.wr(8'h09, 8'h00);
    idle(3);
    chk("dcs staged", {7'h00, dcs}, 8'h01);
    rd_chk(8'h09, 8'h00);
    u_cfg_host.commit();
    chk("commit pulse", {7'h00, pend}, 8'h01);
    idle(1);
    chk("commit pulse end", {7'h00, pend}, 8'h00);
    idle(1);
    chk("dcs off", {7'h00, dcs}, 8'h00);
    act_chk(2'h0, 8'h09, 8'h00);
    // d[c] lands in the bank behind select bit 3-c
    for (int c = 0; c < 4; c++) begin
      d[c] = 8'($urandom);
      u_cfg_host.wr(8'h05, 8'h08 >> c);
      u_cfg_host.wr(8'h20, d[c]);
    end
    chk("select D", {4'h0, csel}, 8'h01);
    act_chk(2'h0, 8'h20, 8'h00);
    u_cfg_host.wr(8'h05, 8'h0f);
    // staged reads come from the bank of the lowest set select bit
    rd_chk(8'h20, d[3]);
    u_cfg_host.commit();
    idle(3);
    // active channel index c reaches the bank of select bit c
    for (int c = 0; c < 4; c++) act_chk(2'(c), 8'h20, d[3-c]);
    u_cfg_host.wr(8'h00, 8'hc0);
    chk("port bits set", {6'h00, sdo_active, lsb_first}, 8'h03);
    u_cfg_host.wr(8'h05, 8'h03);
    u_cfg_host.wr(8'h00, 8'h20);
    idle(3);
    chk("dcs default", {7'h00, dcs}, 8'h01);
    chk("select default", {4'h0, csel}, 8'h0f);
    chk("port default", {6'h00, sdo_active, lsb_first}, 8'h00);
    act_chk(2'h1, 8'h20, 8'h00);
    rd_chk(8'h00, 8'h18);
    u_cfg_host.wr_commit(8'h09, 8'h00);
    idle(3);
    chk("dcs off direct", {7'h00, dcs}, 8'h00);
    idle(4);
    chk("reads left", 8'(exp_q.size()), 8'h00);
    results();
  end
endmodule
